// *** core/drs_status_map.sv ***
// Purpose: Builds the status bits a drive returns to its network master
// Assumes: Drive-side inputs come from logic on clk_sys; master commands are levels
// Notes:   Handshake flags follow their command; fault trip drops station ready
`timescale 1ns/1ps

module drs_status_map
	import drs_pkg::*;
(
	// Clock and reset
	input  wire logic                clk_sys,
	input  wire logic                nrst,
	// Drive state
	input  wire logic                motor_fwd,
	input  wire logic                motor_rev,
	input  wire logic                up_to_speed_signal,
	input  wire logic                overload_signal,
	input  wire logic [FUNC_W-1:0]   func_vec,
	input  wire logic                fault_trip,
	// Configuration
	input  wire drs_cfg_s            cfg,
	// Master commands
	input  wire drs_cmd_s            cmd,
	// Completion sources
	input  wire logic                monitor_stored,
	input  wire logic                ram_stored,
	input  wire logic                nvm_stored,
	input  wire logic                instr_pending,
	// Requests toward drive internals
	output logic                     drive_reset_pulse,
	output logic                     instr_start_pulse,
	// Status image
	output drs_stat_s                stat
);

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_s1_reg;
	logic rst_n;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rst_s1_reg <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n      <= rst_s1_reg;
		end
	end

	// Selector with code zero meaning unassigned
	function automatic logic pick(input logic [FUNC_W-1:0] v, input drs_sel_t s);
		pick = (s == SEL_NONE) ? 1'b0 : v[s];
	endfunction

	// ------------------------------------------------------------
	// Terminal function bits
	// ------------------------------------------------------------
	logic fwd_reg, rev_reg, run_reg, su_reg, ol_reg, fdet_reg, flt_reg;
	logic [2:0] dig_reg;
	logic [3:0] net_reg;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fwd_reg  <= 1'b0;
			rev_reg  <= 1'b0;
			run_reg  <= 1'b0;
			su_reg   <= 1'b0;
			ol_reg   <= 1'b0;
			fdet_reg <= 1'b0;
			flt_reg  <= 1'b0;
			dig_reg  <= 3'h0;
			net_reg  <= 4'h0;
		end else begin
			// Both directions at once is treated as neither
			fwd_reg  <= motor_fwd & ~motor_rev;
			rev_reg  <= motor_rev & ~motor_fwd;
			run_reg  <= pick(func_vec, cfg.run_sel);
			fdet_reg <= pick(func_vec, cfg.fdet_sel);
			flt_reg  <= pick(func_vec, cfg.flt_sel);
			su_reg   <= up_to_speed_signal;
			ol_reg   <= overload_signal;
			for (int i = 0; i < 3; i++) begin
				dig_reg[i] <= pick(func_vec, cfg.dig_sel[i]);
			end
			for (int i = 0; i < 4; i++) begin
				net_reg[i] <= pick(func_vec, cfg.net_sel[i]);
			end
		end
	end

	// ------------------------------------------------------------
	// Command handshakes
	// ------------------------------------------------------------
	logic mon_reg, ram_reg, nvm_reg, ins_reg;
	logic ram_seen_reg;
	logic ins_cmd_d_reg;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mon_reg       <= 1'b0;
			ram_reg       <= 1'b0;
			nvm_reg       <= 1'b0;
			ins_reg       <= 1'b0;
			ram_seen_reg  <= 1'b0;
			ins_cmd_d_reg <= 1'b0;
		end else begin
			ins_cmd_d_reg <= cmd.instr_exec_request;
			// Flags drop as soon as the command falls; rise only while it stands
			if (!cmd.monitor_cmd) mon_reg <= 1'b0;
			else if (monitor_stored) mon_reg <= 1'b1;
			if (!cmd.volatile_write_cmd) ram_reg <= 1'b0;
			else if (ram_stored) ram_reg <= 1'b1;
			if (!cmd.persistent_write_cmd) begin
				nvm_reg      <= 1'b0;
				ram_seen_reg <= 1'b0;
			end else begin
				if (ram_stored) ram_seen_reg <= 1'b1;
				// Nonvolatile store counts only once the working copy is held, before or in the same cycle
				if ((ram_seen_reg | ram_stored) & nvm_stored) nvm_reg <= 1'b1;
			end
			// Done waits one cycle past the start so pending can assert
			if (!cmd.instr_exec_request) ins_reg <= 1'b0;
			else if (ins_cmd_d_reg & !instr_pending & !instr_start_pulse) ins_reg <= 1'b1;
		end
	end
	assign instr_start_pulse = cmd.instr_exec_request & ~ins_cmd_d_reg;

	// ------------------------------------------------------------
	// Error and station ready
	// ------------------------------------------------------------
	typedef enum logic [1:0] {ST_SETUP, ST_READY, ST_FAULT, ST_RECOVER} drs_state_e;
	drs_state_e st_reg;
	logic [SETUP_CNT_W-1:0] setup_cnt_reg;
	logic err_reg, rdy_reg, rst_pulse_reg;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_reg        <= ST_SETUP;
			setup_cnt_reg <= '0;
			err_reg       <= 1'b0;
			rdy_reg       <= 1'b0;
			rst_pulse_reg <= 1'b0;
		end else begin
			rst_pulse_reg <= 1'b0;
			if (fault_trip) begin
				st_reg  <= ST_FAULT;
				err_reg <= 1'b1;
				rdy_reg <= 1'b0;
			end else begin
				unique case (st_reg)
					ST_SETUP: begin
						if (setup_cnt_reg == SETUP_CNT_W'(SETUP_CYCLES - 1)) begin
							st_reg  <= ST_READY;
							rdy_reg <= 1'b1;
						end else begin
							setup_cnt_reg <= setup_cnt_reg + 1'b1;
						end
					end
					ST_READY: ;
					ST_FAULT: begin
						if (cmd.error_reset_request) begin
							st_reg        <= ST_RECOVER;
							rst_pulse_reg <= 1'b1;
						end
					end
					ST_RECOVER: begin
						// Drive reset reruns initial setup before ready returns
						err_reg       <= 1'b0;
						setup_cnt_reg <= '0;
						st_reg        <= ST_SETUP;
					end
				endcase
			end
		end
	end
	assign drive_reset_pulse = rst_pulse_reg;

	// ------------------------------------------------------------
	// Status image
	// ------------------------------------------------------------
	always_comb begin
		stat                       = '0;
		stat.fwd_running_flag      = fwd_reg;
		stat.rev_running_flag      = rev_reg;
		stat.motion_status_bit     = run_reg;
		stat.at_speed_bit          = su_reg;
		stat.overload_warn_bit     = ol_reg;
		stat.net_out1_bit          = net_reg[0];
		stat.freq_detect_bit       = fdet_reg;
		stat.fault_bit             = flt_reg;
		stat.net_out2_bit          = net_reg[1];
		stat.dig_out0_bit          = dig_reg[0];
		stat.dig_out1_bit          = dig_reg[1];
		stat.dig_out2_bit          = dig_reg[2];
		stat.monitor_valid_flag    = mon_reg;
		stat.ram_write_done        = ram_reg;
		stat.persistent_write_done = nvm_reg;
		stat.instr_done_flag       = ins_reg;
		stat.net_out3_bit          = net_reg[2];
		stat.net_out4_bit          = net_reg[3];
		stat.drive_error_flag      = err_reg;
		stat.station_ready_flag    = rdy_reg;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// Terminal bits trail their sources by one register stage
	a_fwd_rev_excl: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!(fwd_reg && rev_reg)) else $error("both direction flags set");
	a_fwd_follows: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(motor_fwd && !motor_rev) |=> fwd_reg) else $error("forward flag missed");
	a_fwd_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!(motor_fwd && !motor_rev) |=> !fwd_reg) else $error("forward flag stray");
	a_rev_follows: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(motor_rev && !motor_fwd) |=> rev_reg) else $error("reverse flag missed");
	a_rev_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!(motor_rev && !motor_fwd) |=> !rev_reg) else $error("reverse flag stray");
	a_run_copy: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(cfg.run_sel != SEL_NONE) |=> run_reg == $past(func_vec[cfg.run_sel]))
		else $error("running bit wrong");
	a_fdet_copy: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(cfg.fdet_sel != SEL_NONE) |=> fdet_reg == $past(func_vec[cfg.fdet_sel]))
		else $error("frequency bit wrong");
	a_flt_copy: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(cfg.flt_sel != SEL_NONE) |=> flt_reg == $past(func_vec[cfg.flt_sel]))
		else $error("fault bit wrong");
	a_fixed_bits: assert property (@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=> su_reg == $past(up_to_speed_signal) && ol_reg == $past(overload_signal))
		else $error("fixed bit wrong");
	// Digital slots 0 and 1 and network slots 0 and 3 stand for the rest; they share the same select logic
	a_dig_empty: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(cfg.dig_sel[0] == SEL_NONE) |=> !dig_reg[0]) else $error("dig bit set unassigned");
	a_dig_copy: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(cfg.dig_sel[1] != SEL_NONE) |=> dig_reg[1] == $past(func_vec[cfg.dig_sel[1]]))
		else $error("dig bit wrong");
	a_net_empty: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(cfg.net_sel[0] == SEL_NONE) |=> !net_reg[0]) else $error("net bit set unassigned");
	a_net_copy: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(cfg.net_sel[3] != SEL_NONE) |=> net_reg[3] == $past(func_vec[cfg.net_sel[3]]))
		else $error("net bit wrong");
	// Handshake flags rise only behind their command and fall with it
	a_mon_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!cmd.monitor_cmd |=> !mon_reg) else $error("monitor flag stuck");
	a_mon_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(mon_reg) |-> $past(monitor_stored && cmd.monitor_cmd))
		else $error("monitor flag early");
	a_ram_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(cmd.volatile_write_cmd && ram_stored) |=> ram_reg) else $error("ram flag missed");
	a_ram_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!cmd.volatile_write_cmd |=> !ram_reg) else $error("ram flag stuck");
	a_nvm_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(nvm_reg) |-> $past(nvm_stored)) else $error("nvm flag early");
	a_nvm_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!cmd.persistent_write_cmd |=> !nvm_reg) else $error("nvm flag stuck");
	a_ins_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!cmd.instr_exec_request |=> !ins_reg) else $error("instr flag stuck");
	a_ins_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(ins_reg) |-> $past(cmd.instr_exec_request && ins_cmd_d_reg && !instr_pending))
		else $error("instr flag early");
	a_start_once: assert property (@(posedge clk_sys) disable iff (!rst_n)
		instr_start_pulse |=> !instr_start_pulse) else $error("start pulse too long");
	// A trip takes priority over any step of setup or recovery
	a_err_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		fault_trip |=> err_reg && !rdy_reg) else $error("fault not flagged");
	a_rdy_setup: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(rdy_reg) |-> setup_cnt_reg == SETUP_CNT_W'(SETUP_CYCLES - 1))
		else $error("ready before setup");
	a_rdy_fault: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(st_reg == ST_FAULT) |-> !rdy_reg) else $error("ready while faulted");
	a_err_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(st_reg == ST_FAULT && cmd.error_reset_request && !fault_trip) |=> drive_reset_pulse
		##1 (!err_reg || $past(fault_trip))) else $error("error not cleared");
	a_reset_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
		drive_reset_pulse |-> $past(st_reg == ST_FAULT && cmd.error_reset_request && !fault_trip))
		else $error("reset pulse unrequested");
	a_err_fall: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(err_reg) |-> $past(st_reg == ST_RECOVER))
		else $error("error cleared early");

	// Main scenarios the bench is expected to reach
	c_monitor: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(mon_reg));
	c_persist: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(nvm_reg));
	c_instr:   cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(ins_reg));
	c_recover: cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(err_reg));
	c_ready:   cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(rdy_reg));

endmodule // drs_status_map

// *** core/drs_pkg.sv ***
// Purpose: Shared types and constants for the drive remote status bit map
// Assumes: One 50 MHz clock; selection codes index a 16-entry function vector
// Notes:   Selection code zero always means no function assigned
package drs_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_MHZ       = 50;
	localparam int unsigned SETUP_TIME_US = 10;
	localparam int unsigned SETUP_CYCLES  = SETUP_TIME_US * CLK_MHZ;
	localparam int unsigned SETUP_CNT_W   = 10;
	localparam int unsigned NVM_WAIT_CYC  = 8;
	localparam int unsigned NVM_CNT_W     = 4;

	// ------------------------------------------------------------
	// Function selection
	// ------------------------------------------------------------
	localparam int unsigned FUNC_W = 16;
	localparam int unsigned SEL_W  = 4;
	typedef logic [SEL_W-1:0] drs_sel_t;

	localparam drs_sel_t SEL_NONE      = 4'h0;
	localparam drs_sel_t SEL_RUN_DFLT  = 4'h1;
	localparam drs_sel_t SEL_FU_DFLT   = 4'h2;
	localparam drs_sel_t SEL_FLT_DFLT  = 4'h3;

	// Reassignable bit selections
	typedef struct packed {
		drs_sel_t run_sel;
		drs_sel_t fdet_sel;
		drs_sel_t flt_sel;
		drs_sel_t [2:0] dig_sel;
		drs_sel_t [3:0] net_sel;
	} drs_cfg_s;

	// Commands from the master
	typedef struct packed {
		logic monitor_cmd;
		logic volatile_write_cmd;
		logic persistent_write_cmd;
		logic instr_exec_request;
		logic error_reset_request;
	} drs_cmd_s;

	// Status image returned to the master
	typedef struct packed {
		logic fwd_running_flag;
		logic rev_running_flag;
		logic motion_status_bit;
		logic at_speed_bit;
		logic overload_warn_bit;
		logic net_out1_bit;
		logic freq_detect_bit;
		logic fault_bit;
		logic net_out2_bit;
		logic dig_out0_bit;
		logic dig_out1_bit;
		logic dig_out2_bit;
		logic monitor_valid_flag;
		logic ram_write_done;
		logic persistent_write_done;
		logic instr_done_flag;
		logic net_out3_bit;
		logic net_out4_bit;
		logic drive_error_flag;
		logic station_ready_flag;
	} drs_stat_s;

endpackage : drs_pkg

// *** sim/drs_master_model.sv ***
// Purpose: Network master side of the cyclic link, raising and dropping commands
// Assumes: Command index 0 monitor, 1 volatile, 2 persistent, 3 instruction, 4 error reset
// Notes:   Error reset counts as complete once the error flag has fallen
`timescale 1ns/1ps

module drs_master_model
	import drs_pkg::*;
(
	// Clock
	input  wire logic      clk_sys,
	// Status from the drive
	input  wire drs_stat_s stat,
	// Commands to the drive
	output drs_cmd_s       cmd
);
	logic [15:0] set_frequency_word;
	logic [15:0] instr_code_word;
	logic [15:0] instr_data_word;

	initial begin
		cmd = '0;
		set_frequency_word = 16'h0000;
		instr_code_word = 16'h0000;
		instr_data_word = 16'h0000;
	end

	function automatic logic flag_of(input int k);
		case (k)
			0: return stat.monitor_valid_flag;
			1: return stat.ram_write_done;
			2: return stat.persistent_write_done;
			3: return stat.instr_done_flag;
			default: return ~stat.drive_error_flag;
		endcase
	endfunction

	// Words are loaded one cycle ahead so the drive never sees a stale value
	task automatic raise(input int k);
		@(posedge clk_sys);
		set_frequency_word <= 16'hE678;
		instr_code_word <= 16'h0101;
		instr_data_word <= 16'h0000;
		@(posedge clk_sys);
		cmd[4-k] <= 1'b1;
	endtask

	task automatic drop(input int k, output int n);
		n = 0;
		while (flag_of(k) !== 1'b1 && n < 50) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		@(posedge clk_sys);
		cmd[4-k] <= 1'b0;
	endtask
endmodule // drs_master_model

// *** sim/drs_status_map_bench.sv ***
// Purpose: Self-checking bench for the drive status bit map
// Assumes: Inputs change by non-blocking assignment at the rising edge
// Notes:   Outputs are sampled 1 ns after the edge that updates them
`timescale 1ns/1ps

module drs_status_map_bench;
	import drs_pkg::*;
	logic        clk_sys, nrst, motor_fwd, motor_rev, fault_trip, instr_pending;
	logic        up_to_speed_signal, overload_signal, drive_reset_pulse, instr_start_pulse;
	logic [15:0] func_vec;
	logic [2:0]  src, ed;
	logic [3:0]  en;
	drs_cfg_s    cfg;
	drs_cmd_s    cmd;
	drs_stat_s   stat;
	int          failures, comparisons, cycles, resets, n;
	localparam logic [2:0] MASK [3] = '{3'b001, 3'b010, 3'b110};

	drs_master_model i_master (.clk_sys(clk_sys), .stat(stat), .cmd(cmd));
	drs_status_map i_dut (.clk_sys(clk_sys), .nrst(nrst), .motor_fwd(motor_fwd),
		.motor_rev(motor_rev), .up_to_speed_signal(up_to_speed_signal),
		.overload_signal(overload_signal), .func_vec(func_vec), .fault_trip(fault_trip),
		.cfg(cfg), .cmd(cmd), .monitor_stored(src[0]), .ram_stored(src[1]),
		.nvm_stored(src[2]), .instr_pending(instr_pending),
		.drive_reset_pulse(drive_reset_pulse), .instr_start_pulse(instr_start_pulse),
		.stat(stat));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// Hang guard: the whole sequence needs well under 3000 cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (resets >= 0 && drive_reset_pulse === 1'b1)
			resets++;
		if (cycles == 4000) begin
			failures++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (failures == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic settle(input int c);
		repeat (c) @(posedge clk_sys);
		#1;
	endtask

	task automatic wait_ready(output int w);
		w = 0;
		while (stat.station_ready_flag !== 1'b1 && w < 700) begin
			settle(1);
			w++;
		end
	endtask

	function automatic logic hit(input drs_sel_t s, input int idx);
		return s != SEL_NONE && int'(s) == idx;
	endfunction

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{nrst, motor_fwd, motor_rev, fault_trip, instr_pending} = '0;
		{up_to_speed_signal, overload_signal, src, func_vec} = '0;
		{failures, comparisons, cycles, resets} = '0;
		cfg = '0;
		cfg.run_sel = SEL_RUN_DFLT;
		cfg.fdet_sel = SEL_FU_DFLT;
		cfg.flt_sel = SEL_FLT_DFLT;
		settle(8);
		check("stat in reset", stat, 32'h0);
		repeat (8) @(posedge clk_sys);
		nrst <= 1'b1;
		settle(400);
		check("early ready", stat.station_ready_flag, 1'b0);
		wait_ready(n);
		check("ready delay", n + 400 >= SETUP_CYCLES && n + 400 <= SETUP_CYCLES + 5, 1'b1);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			motor_fwd <= i[0];
			motor_rev <= i[1];
			settle(1);
			check("fwd", stat.fwd_running_flag, i == 1);
			check("rev", stat.rev_running_flag, i == 2);
		end
		for (int p = 0; p < 2; p++) begin
			@(posedge clk_sys);
			if (p == 1) begin
				cfg.run_sel <= 4'h5;
				cfg.fdet_sel <= 4'h6;
				cfg.flt_sel <= 4'h7;
				for (int k = 0; k < 3; k++) cfg.dig_sel[k] <= drs_sel_t'(8 + k);
				for (int k = 0; k < 4; k++) cfg.net_sel[k] <= drs_sel_t'(11 + k);
			end
			for (int idx = 0; idx < 16; idx++) begin
				@(posedge clk_sys);
				func_vec <= 16'h0001 << idx;
				up_to_speed_signal <= idx[0];
				overload_signal <= idx[1];
				settle(1);
				for (int k = 0; k < 3; k++) ed[k] = hit(cfg.dig_sel[k], idx);
				for (int k = 0; k < 4; k++) en[k] = hit(cfg.net_sel[k], idx);
				check("run", stat.motion_status_bit, hit(cfg.run_sel, idx));
				check("fdet", stat.freq_detect_bit, hit(cfg.fdet_sel, idx));
				check("flt", stat.fault_bit, hit(cfg.flt_sel, idx));
				check("fixed", {stat.at_speed_bit, stat.overload_warn_bit}, {idx[0], idx[1]});
				check("dig", {stat.dig_out2_bit, stat.dig_out1_bit, stat.dig_out0_bit}, ed);
				check("net", {stat.net_out4_bit, stat.net_out3_bit,
					stat.net_out2_bit, stat.net_out1_bit}, en);
			end
		end
		for (int k = 0; k < 3; k++) begin
			@(posedge clk_sys);
			src <= MASK[k];
			@(posedge clk_sys);
			src <= 3'b000;
			settle(1);
			check("stray store", i_master.flag_of(k), 1'b0);
			i_master.raise(k);
			settle(3);
			check("flag early", i_master.flag_of(k), 1'b0);
			if (k == 2) begin
				@(posedge clk_sys);
				src <= 3'b010;
				settle(3);
				check("ram only", i_master.flag_of(k), 1'b0);
			end
			@(posedge clk_sys);
			src <= (k == 2) ? 3'b100 : MASK[k];
			@(posedge clk_sys);
			src <= 3'b000;
			#1;
			check("flag up", i_master.flag_of(k), 1'b1);
			settle(3);
			check("flag stands", i_master.flag_of(k), 1'b1);
			i_master.drop(k, n);
			settle(1);
			check("flag down", i_master.flag_of(k), 1'b0);
		end
		@(posedge clk_sys);
		instr_pending <= 1'b1;
		i_master.raise(3);
		#1;
		check("start pulse", instr_start_pulse, 1'b1);
		settle(4);
		check("pending", {instr_start_pulse, stat.instr_done_flag}, 2'b00);
		@(posedge clk_sys);
		instr_pending <= 1'b0;
		i_master.drop(3, n);
		check("done wait", n >= 1 && n <= 3, 1'b1);
		settle(1);
		check("done down", stat.instr_done_flag, 1'b0);
		@(posedge clk_sys);
		fault_trip <= 1'b1;
		settle(1);
		check("trip", {stat.drive_error_flag, stat.station_ready_flag}, 2'b10);
		i_master.raise(4);
		i_master.drop(4, n);
		@(posedge clk_sys);
		fault_trip <= 1'b0;
		settle(3);
		check("reset refused", {resets[1:0], stat.drive_error_flag}, 3'b001);
		check("no ready", stat.station_ready_flag, 1'b0);
		i_master.raise(4);
		settle(3);
		check("reset taken", {resets[1:0], stat.drive_error_flag}, 3'b010);
		i_master.drop(4, n);
		wait_ready(n);
		check("ready again", n >= SETUP_CYCLES - 8 && n <= SETUP_CYCLES + 5, 1'b1);
		give_verdict();
	end
endmodule // drs_status_map_bench
